// ===== include/rst_wd_pkg.sv
package rst_wd_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_OPTION = 8'h04;
    localparam logic [7:0] ADDR_SERVICE = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    // Field positions
    localparam int BIT_WD_DIS = 0;
    localparam int BIT_CME = 3;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_WD = 2;
    localparam int CAUSE_CM = 3;
    // Service codes
    localparam logic [7:0] WD_ARM_CODE = 8'h55;
    localparam logic [7:0] WD_CLEAR_CODE = 8'haa;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CM_MIN_HZ = 10_000;
    localparam int CM_LIMIT = CLK_HZ / CM_MIN_HZ;
    localparam logic [6:0] RATE_WINDOW = 7'h40;
    localparam logic [7:0] RST_HOLD_CYC = 8'h10;
    // Reset sequencer states
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01,
        ST_WAIT_PIN = 2'b10
    } rst_state_e;
endpackage

// ===== hdl/reset_sources_and_watchdog.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module reset_sources_and_watchdog #(
    parameter int WD_PRE_BITS = 15
) (
    input wire logic ref_clk, // Bus clock
    input wire logic nrst, // Power-on reset, active low
    input wire logic special_mode, // High lifts write-once protection
    input wire logic e_clk_pulse, // Pulse per monitored bus clock edge
    input wire logic rst_pin_in, // Level of reset wire
    output logic rst_pin_out, // Drive level of reset wire
    output logic rst_pin_oe, // High while driving reset wire low
    output logic sys_rst_n, // Core reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr // APB error
);
    import rst_wd_pkg::*;

    localparam int WD_W = WD_PRE_BITS + 6;

    typedef struct packed {
        rst_state_e st;
        logic [7:0] hold;
        logic wd_off;
        logic dis_done;
        logic [1:0] rate;
        logic rate_done;
        logic [6:0] win;
        logic clock_monitor_enable;
        logic armed;
        logic [WD_W-1:0] wd_cnt;
        logic [11:0] cm_cnt;
        logic [3:0] cause;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic oe;
        logic rst_n;
    } state_s;

    state_s s;
    state_s next_s;

    // Terminal count for a rate select
    function automatic logic [WD_W-1:0] wd_limit(input logic [1:0] sel);
        logic [WD_W-1:0] one;
        one = {{(WD_W-1){1'b0}}, 1'b1};
        return (one << (WD_PRE_BITS + 2 * int'(sel))) - one;
    endfunction

    logic run;
    logic wr;
    logic wd_timeout;
    logic cm_fail;

    // Strobes and reset triggers
    always_comb begin
        run = (s.st == ST_RUN);
        wr = psel && penable && s.pready && pwrite && run;
        wd_timeout = run && !s.wd_off && (s.wd_cnt == wd_limit(s.rate));
        cm_fail = run && s.clock_monitor_enable && !e_clk_pulse && (s.cm_cnt == 12'(CM_LIMIT - 1));
    end

    // Next state of the whole block
    always_comb begin
        next_s = s;
        next_s.pready = psel && !penable;
        next_s.pslverr = 1'b0;
        if (psel && !penable) begin
            next_s.prdata = 32'h0;
            if (paddr == ADDR_CONFIG) begin
                next_s.prdata[BIT_WD_DIS] = s.wd_off;
            end else if (paddr == ADDR_OPTION) begin
                next_s.prdata[BIT_CME] = s.clock_monitor_enable;
                next_s.prdata[1:0] = s.rate;
            end else if (paddr == ADDR_SERVICE) begin
                next_s.prdata = 32'h0;
            end else if (paddr == ADDR_STATUS) begin
                next_s.prdata[3:0] = s.cause;
                next_s.prdata[5:4] = s.st;
            end else begin
                next_s.pslverr = 1'b1;
            end
        end
        // Counters of the running system
        if (run) begin
            if (s.win != RATE_WINDOW) begin
                next_s.win = s.win + 7'h1;
            end
            if (!s.wd_off) begin
                next_s.wd_cnt = s.wd_cnt + {{(WD_W-1){1'b0}}, 1'b1};
            end
        end
        // Monitor counter rests at zero whenever the monitor is off, in any state
        if (!s.clock_monitor_enable || e_clk_pulse) begin
            next_s.cm_cnt = 12'h0;
        end else if (run) begin
            next_s.cm_cnt = s.cm_cnt + 12'h1;
        end
        // Register writes
        if (wr) begin
            if (paddr == ADDR_CONFIG) begin
                if (special_mode || !s.dis_done) begin
                    next_s.wd_off = pwdata[BIT_WD_DIS];
                    next_s.dis_done = 1'b1;
                end
            end else if (paddr == ADDR_OPTION) begin
                next_s.clock_monitor_enable = pwdata[BIT_CME];
                if (special_mode || (!s.rate_done && s.win != RATE_WINDOW)) begin
                    next_s.rate = pwdata[1:0];
                    next_s.rate_done = 1'b1;
                end
            end else if (paddr == ADDR_SERVICE) begin
                // Only the two service codes act; any other value is dropped
                if (pwdata[7:0] == WD_ARM_CODE) begin
                    next_s.armed = 1'b1;
                end else if (pwdata[7:0] == WD_CLEAR_CODE && s.armed) begin
                    next_s.armed = 1'b0;
                    next_s.wd_cnt = '0;
                end
            end
        end
        // Reset sequencer
        case (s.st)
            ST_RUN: begin
                if (wd_timeout || cm_fail) begin
                    next_s.st = ST_HOLD;
                    next_s.oe = 1'b1;
                    next_s.hold = 8'h0;
                    next_s.rst_n = 1'b0;
                    next_s.cause = 4'h0;
                    next_s.cause[CAUSE_WD] = wd_timeout;
                    next_s.cause[CAUSE_CM] = cm_fail;
                end else if (!rst_pin_in) begin
                    next_s.st = ST_WAIT_PIN;
                    next_s.rst_n = 1'b0;
                    next_s.cause = 4'h0;
                    next_s.cause[CAUSE_PIN] = 1'b1;
                end
            end
            ST_HOLD: begin
                next_s.hold = s.hold + 8'h1;
                if (s.hold == RST_HOLD_CYC - 8'h1) begin
                    next_s.st = ST_WAIT_PIN;
                    next_s.oe = 1'b0;
                end
            end
            ST_WAIT_PIN: begin
                if (rst_pin_in) begin
                    next_s.st = ST_RUN;
                    next_s.rst_n = 1'b1;
                    next_s.wd_off = 1'b0;
                    next_s.dis_done = 1'b0;
                    next_s.rate = 2'h0;
                    next_s.rate_done = 1'b0;
                    next_s.win = 7'h0;
                    next_s.clock_monitor_enable = 1'b0;
                    next_s.armed = 1'b0;
                    next_s.wd_cnt = '0;
                    next_s.cm_cnt = 12'h0;
                end
            end
            default: begin
                next_s.st = ST_WAIT_PIN;
            end
        endcase
    end

    // State register; power-on lands in pin wait
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.st <= ST_WAIT_PIN;
            s.cause <= 4'h1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register, drive level tied low
    always_comb begin
        rst_pin_out = 1'b0;
        rst_pin_oe = s.oe;
        sys_rst_n = s.rst_n;
        prdata = s.prdata;
        pready = s.pready;
        pslverr = s.pslverr;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_HOLD_DRIVES: assert property (s.st == ST_HOLD |-> rst_pin_oe && !sys_rst_n)
        else $error("reset pin not driven during hold");
    AST_WD_TIMEOUT: assert property (wd_timeout |=> s.st == ST_HOLD ##15 rst_pin_oe ##1 !rst_pin_oe)
        else $error("watchdog timeout did not hold pin 16 cycles");
    AST_CM_FAIL: assert property (cm_fail |=> s.st == ST_HOLD && s.cause[CAUSE_CM])
        else $error("clock monitor failure missed");
    AST_PIN_RESET: assert property (run && !wd_timeout && !cm_fail && !rst_pin_in |=> !sys_rst_n)
        else $error("pin reset ignored");
    AST_WAIT_PIN: assert property (s.st == ST_WAIT_PIN && !rst_pin_in |=> !sys_rst_n)
        else $error("left reset while pin low");
    AST_WD_START: assert property ($rose(sys_rst_n) |=> s.wd_cnt == 1)
        else $error("watchdog not running after reset");
    AST_DIS_ONCE: assert property (run && s.dis_done && !special_mode |=> $stable(s.wd_off))
        else $error("disable bit changed twice");
    AST_RATE_LOCK: assert property (run && s.win == RATE_WINDOW && !special_mode ##1 run
        |-> $stable(s.rate))
        else $error("rate changed after window");
    AST_SERVICE: assert property (wr && paddr == ADDR_SERVICE && pwdata[7:0] == WD_CLEAR_CODE
        && s.armed && !wd_timeout && !cm_fail |=> s.wd_cnt == 0 ##1 s.wd_cnt <= 1)
        else $error("service did not clear count");
    AST_OTHER_VAL: assert property (wr && paddr == ADDR_SERVICE && pwdata[7:0] != WD_ARM_CODE
        && pwdata[7:0] != WD_CLEAR_CODE |=> $stable(s.armed))
        else $error("stray service value changed arm state");
    AST_CM_OFF: assert property (!s.clock_monitor_enable |=> s.cm_cnt == 0)
        else $error("clock monitor counting while off");
endmodule // reset_sources_and_watchdog
`default_nettype wire

// ===== testbench/ext_reset_party.sv
`timescale 1ns/10ps
`default_nettype none
module ext_reset_party (
    input wire logic ref_clk, // Bus clock
    input wire logic hold, // Keep the wire low
    input wire logic req, // Start one pin reset
    input wire logic dev_oe, // Device drives the wire
    input wire logic dev_out, // Device drive level
    output logic lvl // Wire level, pulled up
);
    logic [3:0] cnt = 4'h0;
    // Each request pulls the wire low for eight cycles
    always @(posedge ref_clk) begin
        if (req) begin
            cnt <= 4'h8;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
    // Pull-up wins only while no party pulls low
    assign lvl = ~(hold | (cnt != 4'h0) | (dev_oe & ~dev_out));
endmodule // ext_reset_party
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rst_wd_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic hold = 1'b1, req = 1'b0, pulse = 1'b0, cm_run = 1'b1;
    logic lvl, oe, pout, srn, rdy, serr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int err_count = 0, compares = 0, c, o, oe_cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    // Monitored clock pulses and a tally of driven cycles
    always @(posedge ref_clk) begin
        pulse <= cm_run & ~pulse;
        if (oe === 1'b1) oe_cyc <= oe_cyc + 1;
    end
    ext_reset_party ext (.ref_clk(ref_clk), .hold(hold), .req(req), .dev_oe(oe),
        .dev_out(pout), .lvl(lvl));
    reset_sources_and_watchdog #(.WD_PRE_BITS(4)) uut (.ref_clk(ref_clk), .nrst(nrst),
        .special_mode(1'b0), .e_clk_pulse(pulse), .rst_pin_in(lvl), .rst_pin_out(pout),
        .rst_pin_oe(oe), .sys_rst_n(srn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy), .pslverr(serr));
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t no pready", $time);
            conclude();
        end
        rd = prdata;
        er = serr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Count cycles until reset output (s=0) or pin drive (s=1) shows level v
    task automatic wt(input logic s, input logic v, input int n);
        c = 0;
        while (((s ? oe : srn) !== v) && c <= n) begin
            @(posedge ref_clk);
            c++;
        end
        if (c > n) begin
            err_count++;
            $display("[ERR] %0t wait ran out", $time);
            conclude();
        end
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        chk(srn, 1'b0);
        hold <= 1'b0;
        wt(0, 1'b1, 5);
        apb(0, ADDR_STATUS, 0);
        chk(rd, 32'h1 << CAUSE_POR);
        wt(1, 1'b1, 40);
        chk(c >= 10 && c <= 16, 1);
        chk({lvl, srn}, 0);
        wt(1, 1'b0, 30);
        chk(c, 16);
        wt(0, 1'b1, 5);
        apb(0, ADDR_STATUS, 0);
        chk(rd, 32'h1 << CAUSE_WD);
        $display("test power-on and timeout done");
        apb(1, ADDR_OPTION, 1);
        apb(1, ADDR_OPTION, 2);
        apb(0, ADDR_OPTION, 0);
        chk(rd[3:0], 4'h1);
        o = oe_cyc;
        repeat (6) begin
            apb(1, ADDR_SERVICE, WD_ARM_CODE);
            apb(1, ADDR_SERVICE, 32'h12);
            apb(1, ADDR_SERVICE, WD_CLEAR_CODE);
            repeat (40) @(posedge ref_clk);
        end
        chk(oe_cyc, o);
        apb(1, ADDR_SERVICE, WD_ARM_CODE);
        apb(1, ADDR_SERVICE, WD_CLEAR_CODE);
        repeat (30) @(posedge ref_clk);
        apb(1, ADDR_SERVICE, WD_CLEAR_CODE);
        wt(1, 1'b1, 80);
        chk(c >= 26 && c <= 36, 1);
        $display("test service done");
        wt(1, 1'b0, 30);
        wt(0, 1'b1, 5);
        apb(1, ADDR_CONFIG, 1);
        apb(1, ADDR_CONFIG, 0);
        o = oe_cyc;
        repeat (200) @(posedge ref_clk);
        chk(oe_cyc, o);
        $display("test disable done");
        req <= 1'b1;
        @(posedge ref_clk);
        req <= 1'b0;
        wt(0, 1'b0, 12);
        wt(0, 1'b1, 20);
        apb(0, ADDR_STATUS, 0);
        chk(rd, 32'h1 << CAUSE_PIN);
        apb(1, ADDR_CONFIG, 1);
        $display("test pin reset done");
        apb(1, ADDR_OPTION, 32'h8);
        repeat (300) @(posedge ref_clk);
        chk(srn, 1'b1);
        cm_run <= 1'b0;
        wt(0, 1'b0, 4100);
        chk(c >= 3900, 1);
        wt(0, 1'b1, 40);
        apb(0, ADDR_STATUS, 0);
        chk(rd, 32'h1 << CAUSE_CM);
        apb(1, ADDR_CONFIG, 1);
        repeat (4200) @(posedge ref_clk);
        chk(srn, 1'b1);
        $display("test clock monitor done");
        apb(0, 8'h10, 0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        $display("test unmapped done");
        conclude();
    end
endmodule // tb
`default_nettype wire
